// ===== core/fpec_consts.svh
// Purpose: offsets, field positions, reset values of the flash control block
// Assumes: 32-bit Avalon-MM word registers, byte addresses
// Notes:   definitions only
`ifndef FPEC_CONSTS_SVH
`define FPEC_CONSTS_SVH

// register byte offsets
`define FPEC_OFF_MODE_CTRL   4'h0
`define FPEC_OFF_SETUP_CTRL  4'h4
`define FPEC_OFF_ERASE_BLK   4'h8
`define FPEC_OFF_STATUS      4'hC

// flash_mode_control field positions
`define FPEC_BIT_HW_PROT     7
`define FPEC_BIT_SW_WE       6
`define FPEC_BIT_ERASE_VER   3
`define FPEC_BIT_PROG_VER    2
`define FPEC_BIT_ERASE       1
`define FPEC_BIT_PROG        0

// flash_setup_control field positions
`define FPEC_BIT_ERASE_SU    1
`define FPEC_BIT_PROG_SU     0

// reset values, and the mode register readback while the flash is disabled
`define FPEC_RST_MODE_CTRL   8'h80
`define FPEC_RST_SETUP_CTRL  8'h00
`define FPEC_RST_ERASE_BLK   8'h00
`define FPEC_RD_DISABLED     8'h00

// operating modes in which the flash array is enabled
`define FPEC_OPMODE_FLASH_A  3'h2
`define FPEC_OPMODE_FLASH_B  3'h3

`endif

// ===== core/fpec_pkg.sv
// Purpose: types shared by the flash program/erase control block
// Assumes: nothing beyond the constants header
// Notes:   field order matches the register bit order
package fpec_pkg;

  typedef struct packed {
    logic       hwWriteProtectFlag;
    logic       swWriteEnable;
    logic [1:0] reserved;
    logic       eraseVerifyBit;
    logic       programVerifyBit;
    logic       eraseBit;
    logic       programBit;
  } fpec_mode_ctrl_t;

  typedef struct packed {
    logic [5:0] reserved;
    logic       eraseSetupBit;
    logic       programSetupBit;
  } fpec_setup_ctrl_t;

  typedef struct packed {
    logic standbyHw;
    logic standbySw;
    logic subActive;
    logic subSleep;
    logic watch;
  } fpec_power_t;

  typedef enum logic [2:0] {
    FPEC_IDLE,
    FPEC_PROGRAM,
    FPEC_ERASE,
    FPEC_PROG_VERIFY,
    FPEC_ERASE_VERIFY
  } fpec_state_t;

endpackage : fpec_pkg

// ===== core/fpec_flash_control.sv
// Purpose: software-visible control that gates on-chip flash program and erase
// Assumes: Avalon-MM slave, 32-bit data, byte addresses, one access at a time
// Notes:   power and mode inputs come from outside the domain and are synchronised
`include "fpec_consts.svh"
`timescale 1ns/1ps

module fpec_flash_control
  import fpec_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // chip state pins
  input  wire logic [2:0]  opMode,
  input  wire fpec_power_t powerState,
  // flash array controls
  output logic             programActive,
  output logic             eraseActive,
  output logic             programVerifyActive,
  output logic             eraseVerifyActive,
  output logic [7:0]       eraseBlockSelects,
  output logic             arrayReadBlocked,
  output logic             userProgramAvail
);

  // synchronisers for pins
  logic [2:0]       opModeMeta_q;
  logic [2:0]       opModeSync_q;
  fpec_power_t      powerMeta_q;
  fpec_power_t      powerSync_q;

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      opModeMeta_q <= 3'h0;
      opModeSync_q <= 3'h0;
    end
    else
    begin
      opModeMeta_q <= opMode;
      opModeSync_q <= opModeMeta_q;
    end
  end

  // power levels get their own pair of flops; they only ever clear registers
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      powerMeta_q <= '0;
      powerSync_q <= '0;
    end
    else
    begin
      powerMeta_q <= powerState;
      powerSync_q <= powerMeta_q;
    end
  end

  // derived chip conditions
  wire logic flashEnabled;
  wire logic lowPower;

  assign flashEnabled = (opModeSync_q == `FPEC_OPMODE_FLASH_A)
                     || (opModeSync_q == `FPEC_OPMODE_FLASH_B);
  assign lowPower     = |powerSync_q;

  // registers
  fpec_mode_ctrl_t  modeCtrl_q;
  fpec_mode_ctrl_t  modeCtrl_d;
  fpec_setup_ctrl_t setupCtrl_q;
  fpec_setup_ctrl_t setupCtrl_d;
  logic [7:0]       eraseBlk_q;
  logic [7:0]       eraseBlk_d;

  // bus handshake: a request is answered one cycle after it is seen
  logic             waitReq_q;
  logic [31:0]      readData_q;

  wire logic        request;
  wire logic        accept;
  wire logic        wrAccept;
  wire logic        lane0;
  wire logic [7:0]  wrByte;
  wire logic        hitMode;
  wire logic        hitSetup;
  wire logic        hitBlk;
  wire logic        hitStatus;

  assign request   = avs_read || avs_write;
  assign accept    = request && !waitReq_q;
  assign lane0     = avs_byteenable[0];
  assign wrAccept  = accept && avs_write && lane0;
  assign wrByte    = avs_writedata[7:0];
  assign hitMode   = avs_address == `FPEC_OFF_MODE_CTRL;
  assign hitSetup  = avs_address == `FPEC_OFF_SETUP_CTRL;
  assign hitBlk    = avs_address == `FPEC_OFF_ERASE_BLK;
  assign hitStatus = avs_address == `FPEC_OFF_STATUS;

  // write gates, all judged on held contents so one write cannot open and use a gate
  wire logic gateVerify;
  wire logic gateErase;
  wire logic gateProgram;
  wire logic wrMode;
  wire logic wrSetup;
  wire logic wrBlk;

  assign gateVerify  = modeCtrl_q.swWriteEnable;
  assign gateErase   = modeCtrl_q.swWriteEnable
                    && setupCtrl_q.eraseSetupBit;
  assign gateProgram = modeCtrl_q.swWriteEnable
                    && setupCtrl_q.programSetupBit;
  assign wrMode      = wrAccept && hitMode && flashEnabled;
  // setup and block selects only move with write enable held, which keeps the order
  assign wrSetup     = wrAccept && hitSetup && modeCtrl_q.swWriteEnable;
  assign wrBlk       = wrAccept && hitBlk && modeCtrl_q.swWriteEnable;

  // next value of flash_mode_control
  always_comb
  begin
    modeCtrl_d = modeCtrl_q;
    if (wrMode)
    begin
      modeCtrl_d.swWriteEnable = wrByte[`FPEC_BIT_SW_WE];
      if (gateVerify)
      begin
        modeCtrl_d.eraseVerifyBit   = wrByte[`FPEC_BIT_ERASE_VER];
        modeCtrl_d.programVerifyBit = wrByte[`FPEC_BIT_PROG_VER];
      end
      if (gateErase)
      begin
        modeCtrl_d.eraseBit = wrByte[`FPEC_BIT_ERASE];
      end
      if (gateProgram)
      begin
        modeCtrl_d.programBit = wrByte[`FPEC_BIT_PROG];
      end
    end
    modeCtrl_d.hwWriteProtectFlag = 1'b1;
    modeCtrl_d.reserved           = 2'h0;
  end

  // next value of flash_setup_control
  always_comb
  begin
    setupCtrl_d = setupCtrl_q;
    if (wrSetup)
    begin
      setupCtrl_d.eraseSetupBit   = wrByte[`FPEC_BIT_ERASE_SU];
      setupCtrl_d.programSetupBit = wrByte[`FPEC_BIT_PROG_SU];
    end
    setupCtrl_d.reserved = 6'h00;
  end

  assign eraseBlk_d = wrBlk ? wrByte : eraseBlk_q;

  // register update; low-power entry acts like reset on the control bits
  wire logic clearRegs;

  assign clearRegs = !reset_n || lowPower;

  always_ff @(posedge sys_clk)
  begin
    if (clearRegs)
    begin
      modeCtrl_q <= `FPEC_RST_MODE_CTRL;
    end
    else
    begin
      modeCtrl_q <= modeCtrl_d;
    end
  end

  // setup bits clear with the mode bits so a stale setup cannot survive standby
  always_ff @(posedge sys_clk)
  begin
    if (clearRegs)
    begin
      setupCtrl_q <= `FPEC_RST_SETUP_CTRL;
    end
    else
    begin
      setupCtrl_q <= setupCtrl_d;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (clearRegs)
    begin
      eraseBlk_q <= `FPEC_RST_ERASE_BLK;
    end
    else
    begin
      eraseBlk_q <= eraseBlk_d;
    end
  end

  // operating state, decoded from the held bits
  fpec_state_t state_q;
  fpec_state_t state_d;

  always_comb
  begin
    state_d = FPEC_IDLE;
    if (modeCtrl_q.swWriteEnable && flashEnabled)
    begin
      if (modeCtrl_q.programBit && setupCtrl_q.programSetupBit)
      begin
        state_d = FPEC_PROGRAM;
      end
      else if (modeCtrl_q.eraseBit && setupCtrl_q.eraseSetupBit)
      begin
        state_d = FPEC_ERASE;
      end
      else if (modeCtrl_q.programVerifyBit)
      begin
        state_d = FPEC_PROG_VERIFY;
      end
      else if (modeCtrl_q.eraseVerifyBit)
      begin
        state_d = FPEC_ERASE_VERIFY;
      end
    end
  end

  // readback mux
  wire logic [7:0] modeRead;
  wire logic [7:0] statusRead;
  wire logic [7:0] readByte;

  assign modeRead   = flashEnabled ? modeCtrl_q : `FPEC_RD_DISABLED;
  assign statusRead = {3'h0, flashEnabled, modeCtrl_q.swWriteEnable, state_q};
  assign readByte   = hitMode   ? modeRead
                    : hitSetup  ? setupCtrl_q
                    : hitBlk    ? eraseBlk_q
                    : hitStatus ? statusRead
                    : 8'h00;

  // operating state
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      state_q <= FPEC_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // bus answer: one wait cycle, read data captured while the request waits
  wire logic readCapture;

  assign readCapture = request && waitReq_q && avs_read;

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      waitReq_q  <= 1'b1;
      readData_q <= 32'h0000_0000;
    end
    else
    begin
      waitReq_q  <= !(request && waitReq_q);
      if (readCapture)
      begin
        readData_q <= {24'h00_0000, readByte};
      end
    end
  end

  // state decode for the mode outputs
  wire logic stProgram;
  wire logic stErase;
  wire logic stProgVerify;
  wire logic stEraseVerify;

  assign stProgram     = state_q == FPEC_PROGRAM;
  assign stErase       = state_q == FPEC_ERASE;
  assign stProgVerify  = state_q == FPEC_PROG_VERIFY;
  assign stEraseVerify = state_q == FPEC_ERASE_VERIFY;

  // outputs follow the state one cycle later, each from its own flop
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      programActive       <= 1'b0;
      eraseActive         <= 1'b0;
      programVerifyActive <= 1'b0;
      eraseVerifyActive   <= 1'b0;
    end
    else
    begin
      programActive       <= stProgram;
      eraseActive         <= stErase;
      programVerifyActive <= stProgVerify;
      eraseVerifyActive   <= stEraseVerify;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      eraseBlockSelects <= 8'h00;
      arrayReadBlocked  <= 1'b0;
    end
    else
    begin
      eraseBlockSelects <= eraseBlk_q;
      arrayReadBlocked  <= modeCtrl_q.swWriteEnable;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      userProgramAvail <= 1'b0;
    end
    else
    begin
      userProgramAvail <= flashEnabled;
    end
  end

  assign avs_readdata    = readData_q;
  assign avs_waitrequest = waitReq_q;

endmodule : fpec_flash_control

// ===== verification/fpec_flash_checker.sv
// Purpose: port-level checks of the flash program/erase control block
// Assumes: one clock, synchronous active-low reset
// Notes:   latencies follow the design's flop chain; sync delays get margin
`timescale 1ns/1ps
module fpec_flash_checker
  import fpec_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        reset_n,
  // register bus
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // chip state
  input wire logic [2:0]  opMode,
  input wire fpec_power_t powerState,
  // flash controls
  input wire logic        programActive,
  input wire logic        eraseActive,
  input wire logic        programVerifyActive,
  input wire logic        eraseVerifyActive,
  input wire logic        arrayReadBlocked,
  input wire logic        userProgramAvail
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire logic [3:0] actV = {programActive, eraseActive, programVerifyActive, eraseVerifyActive};
  wire logic       opOk = opMode == 3'h2 || opMode == 3'h3;
  // a completed read of the mode register
  sequence rdMode;
    avs_read && !avs_waitrequest && avs_address == 4'h0;
  endsequence
  one_hot_a: assert property ($onehot0(actV))
    else $error("several flash modes active");
  act_blocked_a: assert property (|actV |-> $past(arrayReadBlocked))
    else $error("flash mode active without write enable");
  blocked_rd_a: assert property (rdMode ##0 avs_readdata[7] |->
    avs_readdata[6] == arrayReadBlocked) else $error("array block differs from enable");
  mode_fields_a: assert property (rdMode |-> avs_readdata[31:8] == 24'h0 &&
    avs_readdata[5:4] == 2'h0 && (avs_readdata[7] || avs_readdata == 32'h0))
    else $error("fixed mode bits wrong");
  disabled_rd_a: assert property (!userProgramAvail [*4] ##0 rdMode |->
    avs_readdata == 32'h0) else $error("disabled flash read not zero");
  avail_on_a: assert property (opOk [*6] |-> userProgramAvail)
    else $error("user program mode missing");
  avail_off_a: assert property (!opOk [*6] |-> !userProgramAvail)
    else $error("user program mode in wrong mode");
  // sync delay plus state and output flops fit in seven cycles
  low_power_a: assert property ((|powerState) [*7] |->
    !arrayReadBlocked && actV == 4'h0) else $error("low power kept flash enabled");
endmodule : fpec_flash_checker
bind fpec_flash_control fpec_flash_checker i_fpec_flash_checker (
  .sys_clk             (sys_clk),
  .reset_n             (reset_n),
  .avs_address         (avs_address),
  .avs_read            (avs_read),
  .avs_readdata        (avs_readdata),
  .avs_waitrequest     (avs_waitrequest),
  .opMode              (opMode),
  .powerState          (powerState),
  .programActive       (programActive),
  .eraseActive         (eraseActive),
  .programVerifyActive (programVerifyActive),
  .eraseVerifyActive   (eraseVerifyActive),
  .arrayReadBlocked    (arrayReadBlocked),
  .userProgramAvail    (userProgramAvail)
);

// ===== verification/test_fpec_flash_control.sv
// Purpose: self-checking bench of the flash program/erase control block
// Assumes: one access per bus task, reference model kept in the bench
// Notes:   random writes from seed 54 after hand-made corner cases
`timescale 1ns/1ps
module test_fpec_flash_control
  import fpec_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [2:0]  opMode = 3'h2;
  fpec_power_t powerState = '0;
  logic [3:0]  actV;
  logic [7:0]  eraseBlockSelects;
  logic        arrayReadBlocked;
  logic        userProgramAvail;
  logic [7:0]  modeM = 8'h80, setupM = 8'h00, blkM = 8'h00;
  logic        flashOn = 1'b1;
  logic [31:0] rdV;
  logic [11:0] seqT [9] = '{12'h04F, 12'h401, 12'h041, 12'h402, 12'h042,
                            12'h044, 12'h400, 12'h048, 12'h000};
  logic [3:0]  addrT [5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
  int          errCount = 0, nTests = 0, seed = 54;

  fpec_flash_control i_fpec_flash_control (
    .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .opMode(opMode), .powerState(powerState),
    .programActive(actV[3]), .eraseActive(actV[2]), .programVerifyActive(actV[1]),
    .eraseVerifyActive(actV[0]), .eraseBlockSelects(eraseBlockSelects),
    .arrayReadBlocked(arrayReadBlocked), .userProgramAvail(userProgramAvail)
  );

  always #2 sys_clk = ~sys_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp)
    begin
      errCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // request held until waitrequest is sampled low; the watchdog bounds the wait
  task automatic busOp(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    avs_write     <= wr;
    avs_read      <= !wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rdV = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : busOp

  // gates judged on contents held before the write
  task automatic wrM(input logic [3:0] a, input logic [7:0] d);
    logic be;
    logic w;
    be = avs_byteenable[0];
    w  = modeM[6] && be;
    busOp(1'b1, a, d);
    if (a == 4'h0 && be && flashOn)
      modeM = {2'b10 | {1'b0, d[6]}, 2'b00, w ? d[3:2] : modeM[3:2],
               w && setupM[1] ? d[1] : modeM[1], w && setupM[0] ? d[0] : modeM[0]};
    if (a == 4'h4 && w)
      setupM = {6'h0, d[1:0]};
    if (a == 4'h8 && w)
      blkM = d;
  endtask : wrM

  function automatic logic [3:0] actExp();
    if (!modeM[6] || !flashOn) return 4'h0;
    if (modeM[0] && setupM[0]) return 4'h8;
    if (modeM[1] && setupM[1]) return 4'h4;
    return {2'h0, modeM[2], modeM[3] && !modeM[2]};
  endfunction : actExp

  // status state code: 0 idle, 1 program, 2 erase, 3 program verify, 4 erase verify
  function automatic logic [2:0] stExp();
    logic [3:0] a;
    a = actExp();
    if (a[3]) return 3'h1;
    if (a[2]) return 3'h2;
    if (a[1]) return 3'h3;
    if (a[0]) return 3'h4;
    return 3'h0;
  endfunction : stExp

  task automatic checkAll();
    busOp(1'b0, 4'h0, 8'h00);
    chk(rdV, flashOn ? {24'h0, modeM} : 32'h0);
    busOp(1'b0, 4'h4, 8'h00);
    chk(rdV, {24'h0, setupM});
    busOp(1'b0, 4'h2, 8'h00);
    chk(rdV, 32'h0);
    busOp(1'b0, 4'hC, 8'h00);
    chk(rdV, {27'h0, flashOn, modeM[6], stExp()});
    chk({actV, arrayReadBlocked, userProgramAvail, eraseBlockSelects},
        {actExp(), modeM[6], flashOn, blkM});
  endtask : checkAll

  task automatic results();
    $display("comparisons %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    errCount++;
    results();
  end

  initial
  begin
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    checkAll();
    foreach (seqT[i])
    begin
      wrM(seqT[i][11:8], seqT[i][7:0]);
      checkAll();
    end
    $display("corner sequence done");
    for (int i = 0; i < 5; i++)
    begin
      wrM(4'h0, 8'h40);
      wrM(4'h4, 8'h01);
      wrM(4'h8, 8'hA5);
      powerState <= fpec_power_t'(5'h01 << i);
      repeat (8) @(posedge sys_clk);
      powerState <= '0;
      modeM = 8'h80;
      setupM = 8'h00;
      blkM = 8'h00;
      repeat (4) @(posedge sys_clk);
      checkAll();
    end
    $display("low power done");
    wrM(4'h0, 8'h40);
    wrM(4'h4, 8'h02);
    reset_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    modeM = 8'h80;
    setupM = 8'h00;
    blkM = 8'h00;
    repeat (3) @(posedge sys_clk);
    checkAll();
    $display("mid-run reset done");
    for (int o = 0; o < 8; o++)
    begin
      opMode <= o[2:0];
      flashOn = (o == 2 || o == 3);
      repeat (6) @(posedge sys_clk);
      wrM(4'h0, 8'($random(seed)));
      checkAll();
    end
    $display("operating modes done");
    // random writes need flash enabled, else every mode write is ignored
    opMode <= 3'h3;
    flashOn = 1'b1;
    repeat (6) @(posedge sys_clk);
    repeat (150)
    begin
      avs_byteenable <= 4'($random(seed)) | 4'h6;
      @(posedge sys_clk);
      wrM(addrT[{$random(seed)} % 5], 8'($random(seed)));
      checkAll();
    end
    $display("random writes done");
    results();
  end
endmodule : test_fpec_flash_control
